// [tgm_tx_framing.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tgm_params.svh"
module tgm_tx_framing #(
	parameter int DATA_W = 64
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire tgm_pkg::tgm_beat_t s_axis_beat,
	input wire logic s_axis_tvalid,
	output logic s_axis_tready,
	input wire logic [7:0] tx_ifg_delay,
	input wire tgm_pkg::tgm_cfg_t cfg,
	input wire logic rx_local_fault,
	input wire logic rx_remote_fault,
	output tgm_pkg::tgm_xgmii_t xgmii_tx,
	output logic [1:0] status_vector,
	output logic [31:0] reconciliation_config_word
);
	import tgm_pkg::*;

	// =====================================================================
	// elaboration check: only the 64-bit lane layout is built
	generate
		if (DATA_W != 64) begin : g_bad_width
			$error("tgm_tx_framing supports DATA_W of 64 only");
		end
	endgenerate

	function automatic logic [3:0] pop8(input logic [7:0] k);
		logic [3:0] n;
		n = 4'd0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'd0, k[i]};
		end
		return n;
	endfunction

	function automatic tgm_xgmii_t fill_word(input logic [7:0] ch);
		tgm_xgmii_t w;
		w.txd = {8{ch}};
		w.txc = 8'hff;
		return w;
	endfunction

	// =====================================================================
	// fault input synchronisers, fault flags come from the receive side
	logic [1:0] lf_sync_ff;
	logic [1:0] rf_sync_ff;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lf_sync_ff <= 2'b00;
			rf_sync_ff <= 2'b00;
		end else begin
			lf_sync_ff <= {lf_sync_ff[0], rx_local_fault};
			rf_sync_ff <= {rf_sync_ff[0], rx_remote_fault};
		end
	end
	logic lf_seen;
	logic rf_seen;
	logic fault_block;
	assign lf_seen = lf_sync_ff[1];
	assign rf_seen = rf_sync_ff[1];
	// inhibit lets frames through whatever the far end reports
	assign fault_block = (lf_seen | rf_seen) & ~cfg.fault_inhibit;
	// status straight from the second sync stage
	assign status_vector[`TGM_STAT_LF_BIT] = lf_seen;
	assign status_vector[`TGM_STAT_RF_BIT] = rf_seen;
	always_comb begin
		reconciliation_config_word = 32'h0000_0000;
		reconciliation_config_word[`TGM_RS_LF_BIT] = lf_seen;
		reconciliation_config_word[`TGM_RS_RF_BIT] = rf_seen;
	end

	// =====================================================================
	// framing state
	tgm_state_t st_ff, nxt_st;
	tgm_xgmii_t xg_ff, nxt_xg;
	logic [`TGM_LEN_W-1:0] len_ff, nxt_len;
	logic err_ff, nxt_err;
	logic drop_ff, nxt_drop;
	logic tag_ff, nxt_tag;
	logic [1:0] beat_ff, nxt_beat;
	// one bit above the longest requested gap, so the count cannot wrap and hang
	logic [10:0] idle_ff, nxt_idle;
	logic [9:0] def_ff, nxt_def;
	logic tready;
	logic [3:0] pop;
	logic [`TGM_LEN_W-1:0] lim;
	logic [`TGM_LEN_W-1:0] sum;
	logic over;
	logic err_n;
	logic [9:0] tgt;
	logic [9:0] allow;
	logic [15:0] tpid;
	tgm_xgmii_t quiet;

	assign s_axis_tready = tready;
	assign xgmii_tx = xg_ff;

	// next values for the whole frame path; the link output is registered, ready comes straight from this logic
	always_comb begin
		nxt_st = st_ff;
		nxt_xg = fill_word(`TGM_CH_IDLE);
		nxt_len = len_ff;
		nxt_err = err_ff;
		nxt_drop = drop_ff;
		nxt_tag = tag_ff;
		nxt_beat = beat_ff;
		nxt_idle = idle_ff;
		nxt_def = def_ff;
		tready = 1'b0;
		pop = pop8(s_axis_beat.tkeep);
		sum = len_ff + {10'd0, pop};
		tpid = {s_axis_beat.tdata[39:32], s_axis_beat.tdata[47:40]};
		// jumbo first, then programmed limit, then tag-extended limit
		if (cfg.custom_length_limit_enable) begin
			lim = cfg.mtu_size;
		end else if (cfg.tagged_frame_enable && tag_ff) begin
			lim = `TGM_MAX_TAGGED;
		end else begin
			lim = `TGM_MAX_UNTAGGED;
		end
		over = ~cfg.jumbo_en && (sum > lim);
		// abort flag sampled only on accepted beats
		err_n = err_ff | s_axis_beat.tuser | over;
		// requested gap never below three columns
		if (cfg.ifg_adjust_en && tx_ifg_delay > `TGM_MIN_GAP_COLS) begin
			tgt = {tx_ifg_delay, 2'b00};
		end else begin
			tgt = `TGM_MIN_GAP_BYTES;
		end
		allow = cfg.idle_deficit_balancing ? (`TGM_DIC_MAX - def_ff) : 10'd0;
		// local fault seen: answer with remote fault sets; remote seen: idle
		quiet = fill_word(`TGM_CH_IDLE);
		if (fault_block && lf_seen) begin
			quiet.txd = {2{`TGM_CH_RFLT, 8'h00, 8'h00, `TGM_CH_SEQ}};
			quiet.txc = 8'h11;
		end
		case (st_ff)
			ST_IDLE: begin
				nxt_xg = quiet;
				nxt_len = '0;
				nxt_err = 1'b0;
				nxt_drop = 1'b0;
				nxt_tag = 1'b0;
				nxt_beat = 2'd0;
				if (fault_block) begin
					// swallow whatever the client offers
					tready = 1'b1;
					if (s_axis_tvalid && !s_axis_beat.tlast) begin
						nxt_st = ST_DROP;
					end
				end else if (s_axis_tvalid) begin
					nxt_st = ST_DATA;
					nxt_xg.txc = 8'h01;
					if (cfg.custom_preamble_en) begin
						// first beat is preamble, consumed here
						tready = 1'b1;
						nxt_xg.txd = {s_axis_beat.tdata[55:0], `TGM_CH_START};
					end else begin
						nxt_xg.txd = {`TGM_CH_SFD, {6{`TGM_CH_PRE}}, `TGM_CH_START};
					end
				end
			end
			ST_DATA: begin
				tready = 1'b1;
				if (!s_axis_tvalid) begin
					// starved mid-frame: mark errored, wait for the client
					nxt_err = 1'b1;
					nxt_xg = fill_word(`TGM_CH_ERR);
				end else begin
					nxt_len = sum;
					nxt_err = err_n;
					if (beat_ff != 2'd3) begin
						nxt_beat = beat_ff + 2'd1;
					end
					if (beat_ff == `TGM_TAG_BEAT && (tpid == `TGM_TPID_VLAN ||
						(cfg.qinq_en && tpid == `TGM_TPID_QINQ))) begin
						nxt_tag = 1'b1;
					end
					for (int i = 0; i < 8; i++) begin
						if (s_axis_beat.tkeep[i]) begin
							nxt_xg.txd[8*i +: 8] = err_n ? `TGM_CH_ERR : s_axis_beat.tdata[8*i +: 8];
							nxt_xg.txc[i] = err_n;
						end else if (s_axis_beat.tlast && pop == 4'(i)) begin
							nxt_xg.txd[8*i +: 8] = `TGM_CH_TERM;
						end
					end
					if (over) begin
						// truncate: errored word, terminate, drop the rest
						nxt_xg = fill_word(`TGM_CH_ERR);
						nxt_st = ST_TERM;
						nxt_drop = ~s_axis_beat.tlast;
					end else if (s_axis_beat.tlast) begin
						if (pop == 4'd8) begin
							nxt_st = ST_TERM;
						end else begin
							nxt_st = ST_IFG;
							nxt_idle = 11'd7 - {7'd0, pop};
						end
					end
				end
			end
			ST_TERM: begin
				nxt_xg.txd[7:0] = `TGM_CH_TERM;
				nxt_idle = 11'd7;
				nxt_st = drop_ff ? ST_DROP : ST_IFG;
			end
			ST_DROP: begin
				// discard the tail of a truncated or fault-blocked frame
				nxt_xg = quiet;
				tready = 1'b1;
				if (s_axis_tvalid && s_axis_beat.tlast) begin
					nxt_st = ST_IFG;
					nxt_idle = 11'd0;
				end
			end
			ST_IFG: begin
				// back pressure while the gap runs
				nxt_xg = quiet;
				nxt_idle = idle_ff + {1'b0, `TGM_WORD_BYTES};
				// balancing may shorten the gap, never under twelve bytes
				if (nxt_idle >= {1'b0, `TGM_MIN_GAP_BYTES} &&
					nxt_idle + {1'b0, allow} >= {1'b0, tgt}) begin
					nxt_st = ST_IDLE;
					// in the narrowing branch the deficit never rises above three
					if (nxt_idle < {1'b0, tgt}) begin
						nxt_def = def_ff + (tgt - nxt_idle[9:0]);
					end else if (nxt_idle - {1'b0, tgt} >= {1'b0, def_ff}) begin
						nxt_def = 10'd0;
					end else begin
						nxt_def = def_ff - (nxt_idle[9:0] - tgt);
					end
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	// registers of the frame path
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= ST_IDLE;
			xg_ff <= '{txd: {8{`TGM_CH_IDLE}}, txc: 8'hff};
			len_ff <= '0;
			err_ff <= 1'b0;
			drop_ff <= 1'b0;
			tag_ff <= 1'b0;
			beat_ff <= 2'd0;
			idle_ff <= {1'b0, `TGM_MIN_GAP_BYTES};
			def_ff <= 10'd0;
		end else begin
			st_ff <= nxt_st;
			xg_ff <= nxt_xg;
			len_ff <= nxt_len;
			err_ff <= nxt_err;
			drop_ff <= nxt_drop;
			tag_ff <= nxt_tag;
			beat_ff <= nxt_beat;
			idle_ff <= nxt_idle;
			def_ff <= nxt_def;
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	logic beat_ok;
	assign beat_ok = s_axis_tvalid & tready;
	// link watch for the gap floor: a terminate in lanes 4..7 leaves under four idles in its word
	logic chk_term_any;
	logic chk_term_late;
	logic chk_start;
	always_comb begin
		chk_term_any = 1'b0;
		chk_term_late = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (xgmii_tx.txc[i] && xgmii_tx.txd[8*i +: 8] == `TGM_CH_TERM) begin
				chk_term_any = 1'b1;
				chk_term_late = chk_term_late | (i >= 4);
			end
		end
	end
	assign chk_start = xgmii_tx.txc[0] && xgmii_tx.txd[7:0] == `TGM_CH_START;

	a_abort_errors: assert property ((st_ff == ST_DATA && beat_ok && s_axis_beat.tuser && s_axis_beat.tkeep[0])
		|=> xgmii_tx.txc[0] && xgmii_tx.txd[7:0] == `TGM_CH_ERR) else $error("abort beat not errored");
	a_starve_errors: assert property ((st_ff == ST_DATA && !s_axis_tvalid)
		|=> xgmii_tx.txd == {8{`TGM_CH_ERR}} ##0 err_ff) else $error("implicit underrun not errored");
	a_trunc_term: assert property ((st_ff == ST_DATA && beat_ok && over)
		|=> xgmii_tx.txc == 8'hff ##1 xgmii_tx.txd[7:0] == `TGM_CH_TERM) else $error("oversize frame not truncated");
	a_gap_hold: assert property ((st_ff == ST_IFG) |-> !s_axis_tready && nxt_xg.txc[0])
		else $error("ready high during gap");
	a_gap_floor: assert property (chk_term_any |=> !chk_start)
		else $error("start right after terminate");
	a_gap_floor_late: assert property (chk_term_late |=> ##1 !chk_start)
		else $error("gap shorter than three columns");
	a_fault_silent: assert property ((st_ff == ST_IDLE && fault_block)
		|-> s_axis_tready ##1 !(xgmii_tx.txc[0] && xgmii_tx.txd[7:0] == `TGM_CH_START)) else $error("frame sent under fault");
	a_rf_answer: assert property ((st_ff == ST_IDLE && lf_seen && !cfg.fault_inhibit)
		|=> xgmii_tx.txd[7:0] == `TGM_CH_SEQ && xgmii_tx.txd[31:24] == `TGM_CH_RFLT) else $error("no remote fault answer");
	a_custom_pre: assert property ((st_ff == ST_IDLE && !fault_block && s_axis_tvalid && cfg.custom_preamble_en)
		|=> xgmii_tx.txd[63:8] == $past(s_axis_beat.tdata[55:0])) else $error("custom preamble not substituted");
	a_status_word: assert property (reconciliation_config_word ==
		{2'b00, status_vector[1], status_vector[0], 28'h0000000}) else $error("config word fault bits differ");
	a_status_sync: assert property ($rose(lf_sync_ff[0]) |=> status_vector[0])
		else $error("local fault status late");

	c_abort: cover property (st_ff == ST_DATA && beat_ok && s_axis_beat.tuser);
	c_starve: cover property (st_ff == ST_DATA && !s_axis_tvalid ##1 s_axis_tvalid);
	c_truncate: cover property (st_ff == ST_DATA && beat_ok && over);
	c_fault_drop: cover property (st_ff == ST_DROP && fault_block);
endmodule
`default_nettype wire

// [tgm_params.svh]
`ifndef TGM_PARAMS_SVH
`define TGM_PARAMS_SVH
// =====================================================================
// link control characters
`define TGM_CH_IDLE 8'h07
`define TGM_CH_START 8'hfb
`define TGM_CH_TERM 8'hfd
`define TGM_CH_ERR 8'hfe
`define TGM_CH_PRE 8'h55
`define TGM_CH_SFD 8'hd5
`define TGM_CH_SEQ 8'h9c
`define TGM_CH_RFLT 8'h02
// =====================================================================
// frame length limits and tag types
`define TGM_LEN_W 14
`define TGM_MAX_UNTAGGED 14'd1518
`define TGM_MAX_TAGGED 14'd1522
`define TGM_TPID_VLAN 16'h8100
`define TGM_TPID_QINQ 16'h88a8
`define TGM_TAG_BEAT 2'd1
// =====================================================================
// gap timing, in bytes and four-byte columns
`define TGM_MIN_GAP_COLS 8'd3
`define TGM_MIN_GAP_BYTES 10'd12
`define TGM_WORD_BYTES 10'd8
`define TGM_DIC_MAX 10'd3
// =====================================================================
// fault status positions and config word address
`define TGM_RS_CFG_OFFSET 16'h0410
`define TGM_RS_LF_BIT 28
`define TGM_RS_RF_BIT 29
`define TGM_STAT_LF_BIT 0
`define TGM_STAT_RF_BIT 1
`endif

// [tgm_pkg.sv]
package tgm_pkg;
	// client beat, lanes of 8 bits each
	typedef struct packed {
		logic [63:0] tdata;
		logic [7:0] tkeep;
		logic tuser;
		logic tlast;
	} tgm_beat_t;
	typedef struct packed {
		logic jumbo_en;
		logic tagged_frame_enable;
		logic qinq_en;
		logic custom_length_limit_enable;
		logic [13:0] mtu_size;
		logic ifg_adjust_en;
		logic idle_deficit_balancing;
		logic custom_preamble_en;
		logic fault_inhibit;
	} tgm_cfg_t;
	typedef struct packed {
		logic [63:0] txd;
		logic [7:0] txc;
	} tgm_xgmii_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_DATA = 6'b000010,
		ST_TERM = 6'b000100,
		ST_DROP = 6'b001000,
		ST_IFG = 6'b010000,
		ST_SPARE = 6'b100000
	} tgm_state_t;
endpackage

// [tgm_client_model.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// client fifo model: whole frames, header bytes first
module tgm_client_model (
	input wire logic clk_sys,
	input wire logic s_axis_tready,
	output var tgm_pkg::tgm_beat_t s_axis_beat,
	output logic s_axis_tvalid
);
	import tgm_pkg::*;
	tgm_beat_t b;
	// tag type put in beat 1 lanes 4 and 5 when nonzero; keep of the closing beat
	logic [15:0] tag_type = 16'h0000;
	logic [7:0] last_keep = 8'h0f;
	initial begin
		s_axis_beat = '0;
		s_axis_tvalid = 1'b0;
	end
	// hold the beat until ready is seen at an edge
	task automatic put(input tgm_beat_t bt);
		s_axis_beat = bt;
		s_axis_tvalid = 1'b1;
		// no limit here: a stuck ready is left to the bench watchdog
		do begin
			@(negedge clk_sys);
		end while (s_axis_tready !== 1'b1);
		@(posedge clk_sys);
		#1;
	endtask
	// released lines show the inverse, so a stale abort flag is present too
	task automatic rest(input int n);
		s_axis_tvalid = 1'b0;
		s_axis_beat = ~s_axis_beat;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// ab: abort beat, sb: starve before beat, hold: valid stays high after
	task automatic send(input int nb, input int ab, input int sb, input logic [63:0] pre,
		input logic hold);
		int i;
		if (pre !== 64'h0) put('{tdata: pre, tkeep: 8'hff, tuser: 1'b0, tlast: 1'b0});
		for (i = 0; i < nb; i++) begin
			if (i == sb) rest(3);
			b.tdata = {8{i[7:0] + 8'h11}};
			if (i == 1 && tag_type !== 16'h0000) b.tdata[47:32] = {tag_type[7:0], tag_type[15:8]};
			b.tkeep = (i == nb - 1) ? last_keep : 8'hff;
			b.tuser = (i == ab);
			b.tlast = (i == nb - 1);
			put(b);
		end
		if (!hold) rest(1);
	endtask
endmodule
`default_nettype wire

// [tenge_mac_tx_client_framing_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// bench top
module tenge_mac_tx_client_framing_tb_top;
	import tgm_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	tgm_beat_t beat;
	logic tvalid;
	logic tready;
	logic [7:0] tx_ifg_delay = 8'h00;
	tgm_cfg_t cfg = '0;
	logic lf = 1'b0;
	logic rf = 1'b0;
	tgm_xgmii_t xg;
	logic [1:0] stat;
	logic [31:0] rcw;
	int errors = 0;
	int n_checks = 0;
	int n_start = 0;
	int n_err = 0;
	int gap = 0;
	int last_gap = 0;
	logic [63:0] start_txd;
	logic [7:0] start_txc;
	always #50 clk_sys = ~clk_sys;
	tgm_tx_framing u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .s_axis_beat(beat), .s_axis_tvalid(tvalid),
		.s_axis_tready(tready), .tx_ifg_delay(tx_ifg_delay), .cfg(cfg), .rx_local_fault(lf),
		.rx_remote_fault(rf), .xgmii_tx(xg), .status_vector(stat), .reconciliation_config_word(rcw));
	tgm_client_model u_client (.clk_sys(clk_sys), .s_axis_tready(tready), .s_axis_beat(beat),
		.s_axis_tvalid(tvalid));
	// =====================================================
	// link watcher: starts, error codes, words from terminate to start
	always @(posedge clk_sys) begin
		gap <= gap + 1;
		if (xg.txc[0] && xg.txd[7:0] == 8'hfb) begin
			n_start <= n_start + 1;
			start_txd <= xg.txd;
			start_txc <= xg.txc;
			last_gap <= gap;
		end
		for (int l = 0; l < 8; l++) begin
			if (xg.txc[l] && xg.txd[8*l+:8] == 8'hfe) n_err <= n_err + 1;
			if (xg.txc[l] && xg.txd[8*l+:8] == 8'hfd) gap <= 0;
		end
	end
	// =====================================================
	// shared helpers
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic clear();
		n_start = 0;
		n_err = 0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// =====================================================
	// scenarios
	task automatic t_plain();
		clear();
		u_client.send(2, -1, -1, 64'h0, 1'b0);
		idle(8);
		check(n_start == 1 && start_txd === 64'hd5555555555555fb && start_txc === 8'h01, "start word");
		check(n_err == 0, "clean frame errored");
		$display("test plain done");
	endtask
	task automatic t_under();
		clear();
		u_client.send(4, 1, -1, 64'h0, 1'b0);
		idle(8);
		check(n_err > 0 && n_start == 1, "abort not errored");
		clear();
		u_client.send(4, -1, 2, 64'h0, 1'b0);
		idle(8);
		check(n_err > 0 && n_start == 1, "starve not errored");
		$display("test underrun done");
	endtask
	task automatic t_len();
		logic jm[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		logic me[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		logic [13:0] ms[5] = '{14'd0, 14'd0, 14'd1530, 14'd2000, 14'd1530};
		logic bad[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++) begin
			cfg.jumbo_en = jm[i];
			cfg.custom_length_limit_enable = me[i];
			cfg.mtu_size = ms[i];
			clear();
			u_client.send(200, -1, -1, 64'h0, 1'b0);
			idle(8);
			check((n_err > 0) == bad[i], "length limit");
		end
		cfg = '0;
		$display("test length done");
	endtask
	// 1522-byte frames: fit only when tagged, and only under the tag limit
	task automatic t_tag();
		logic [15:0] ty[5] = '{16'h8100, 16'h0000, 16'h88a8, 16'h88a8, 16'h8100};
		logic qq[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		logic me[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		logic bad[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
		cfg.tagged_frame_enable = 1'b1;
		u_client.last_keep = 8'h03;
		for (int i = 0; i < 5; i++) begin
			cfg.qinq_en = qq[i];
			cfg.custom_length_limit_enable = me[i];
			cfg.mtu_size = 14'd1520;
			u_client.tag_type = ty[i];
			clear();
			u_client.send(191, -1, -1, 64'h0, 1'b0);
			idle(8);
			check(n_start == 1 && (n_err > 0) == bad[i], "tag length");
		end
		u_client.tag_type = 16'h0000;
		u_client.last_keep = 8'h0f;
		cfg = '0;
		$display("test tag done");
	endtask
	task automatic t_gap();
		logic ad[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
		logic [7:0] dl[4] = '{8'h00, 8'h02, 8'h10, 8'h05};
		logic dc[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
		// full idle words between frames; the last one is shortened by balancing
		int lo[4] = '{2, 2, 8, 2};
		for (int i = 0; i < 4; i++) begin
			cfg.ifg_adjust_en = ad[i];
			cfg.idle_deficit_balancing = dc[i];
			tx_ifg_delay = dl[i];
			u_client.send(2, -1, -1, 64'h0, 1'b1);
			u_client.send(2, -1, -1, 64'h0, 1'b0);
			idle(20);
			check(last_gap == lo[i], "gap length");
		end
		cfg = '0;
		$display("test gap done");
	endtask
	task automatic t_pre();
		cfg.custom_preamble_en = 1'b1;
		clear();
		u_client.send(3, -1, -1, 64'h0011223344556677, 1'b0);
		idle(8);
		check(n_start == 1 && start_txd === 64'h11223344556677fb && start_txc === 8'h01, "preamble");
		cfg = '0;
		$display("test preamble done");
	endtask
	task automatic t_fault();
		lf = 1'b1;
		idle(3);
		check(stat === 2'b01 && rcw === 32'h10000000, "local status");
		idle(4);
		check(xg.txd === 64'h0200009c0200009c && xg.txc === 8'h11, "remote fault sets");
		clear();
		u_client.send(3, -1, -1, 64'h0, 1'b0);
		idle(8);
		check(n_start == 0, "frame not dropped");
		cfg.fault_inhibit = 1'b1;
		u_client.send(3, -1, -1, 64'h0, 1'b0);
		idle(8);
		check(n_start == 1, "inhibit frame");
		cfg.fault_inhibit = 1'b0;
		lf = 1'b0;
		rf = 1'b1;
		idle(4);
		check(stat === 2'b10 && rcw === 32'h20000000, "remote status");
		check(xg.txd === 64'h0707070707070707 && xg.txc === 8'hff, "idle on remote");
		rf = 1'b0;
		idle(4);
		$display("test fault done");
	endtask
	// =====================================================
	// main sequence and watchdog sized for about ten times the run
	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		t_plain();
		t_under();
		t_len();
		t_tag();
		t_gap();
		t_pre();
		t_fault();
		close_out();
	end
	initial begin
		#2000000;
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
